// ==== core/timer_pkg.sv ====
// Constants, field layouts and carrier types of the prescaler and timer block
package timer_pkg;

    // --------
    // Sizes
    // --------
    localparam int NUM_TIMERS = 3;
    localparam int CNT_W      = 24;
    localparam int PRE_W      = 21;
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 8;

    // --------
    // Register byte offsets
    // --------
    localparam logic [7:0] OFS_SETUP      = 8'h00;
    localparam logic [7:0] OFS_PCOUNT     = 8'h04;
    localparam logic [7:0] OFS_TIMER_BASE = 8'h10;
    localparam logic [7:0] TIMER_STRIDE   = 8'h10;
    localparam logic [3:0] OFS_CSR        = 4'h0;
    localparam logic [3:0] OFS_START      = 4'h4;
    localparam logic [3:0] OFS_MATCH      = 4'h8;
    localparam logic [3:0] OFS_COUNT      = 4'hC;

    // --------
    // Field positions
    // --------
    localparam int SRC_LSB   = 21;
    localparam int ON_BIT    = 0;
    localparam int OIE_BIT   = 1;
    localparam int CIE_BIT   = 2;
    localparam int MODE_LSB  = 4;
    localparam int DIR_BIT   = 11;
    localparam int DIN_BIT   = 12;
    localparam int DOUT_BIT  = 13;
    localparam int PCE_BIT   = 15;
    localparam int OVF_BIT   = 20;
    localparam int MATCH_BIT = 21;

    // --------
    // Reset values and codes
    // --------
    localparam logic [PRE_W-1:0] PRELOAD_RST = 21'h000000;
    localparam logic [1:0]       SRC_RST     = 2'h0;
    localparam logic [CNT_W-1:0] CNT_RST     = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_MAX     = 24'hFFFFFF;
    localparam logic [1:0]       SRC_CLK2    = 2'h0;
    localparam logic [1:0]       SRC_PIN     = 2'h1;

    localparam logic [3:0] MODE_GPIO      = 4'h0;
    localparam logic [3:0] MODE_PULSE     = 4'h1;
    localparam logic [3:0] MODE_TOGGLE    = 4'h2;
    localparam logic [3:0] MODE_EVENT     = 4'h3;
    localparam logic [3:0] MODE_WIDTH     = 4'h4;
    localparam logic [3:0] MODE_PERIOD    = 4'h5;
    localparam logic [3:0] MODE_CAPTURE   = 4'h6;
    localparam logic [3:0] MODE_PWM       = 4'h7;
    localparam logic [3:0] MODE_WD_PULSE  = 4'h9;
    localparam logic [3:0] MODE_WD_TOGGLE = 4'hA;

    // --------
    // Carriers
    // --------
    typedef struct packed {
        logic       use_prescaler_bit;
        logic       dout;
        logic       dir;
        logic [3:0] mode;
        logic       cie;
        logic       oie;
        logic       on;
    } timer_ctrl_t;

    localparam timer_ctrl_t CTRL_RST = '0;

    typedef struct packed {
        logic [PRE_W-1:0] preload;
        logic [1:0]       src;
    } divider_setup_t;

endpackage

// ==== core/timer_prescaler_and_control.sv ====
// Shared prescaler and three timer control/status units behind an AHB-Lite slave
// Function
// [RULE_01] Preload reloads counter at zero or enable
// [RULE_02] Divide factor equals preload plus one
// [RULE_03] Resets clear preload and source fields
// [RULE_04] Source 00 internal half clock, 01 pin
// [RULE_05] Prescaler pin use ignores timer 0 settings
// [RULE_06] External source counts synchronized pin transitions
// [RULE_07] External source below quarter internal frequency
// [RULE_08] Change source only while prescaler disabled
// [RULE_09] Setup bit 23 reads zero
// [RULE_10] Count register read-only, upper bits zero
// [RULE_11] Enable clears counter; clearing disables timer
// [RULE_12] Disabled non-GPIO timer 0 floats pin
// [RULE_13] Wrap from all-ones raises overflow interrupt
// [RULE_14] Match raises compare interrupt in counting modes
// [RULE_15] Count up from start value
// [RULE_16] Timer 0 modes zero to three
// [RULE_17] Timer 0 modes four to ten
// [RULE_18] GPIO only when mode field zero
// [RULE_19] Event mode counts synchronized pin transitions
// [RULE_20] Resets clear mode, enable, interrupt enables
// [RULE_21] Change mode only while timer disabled
// [RULE_22] Timers 1 and 2 only mode zero
// [RULE_23] Prescaler decrements, runs when timer uses it
// [RULE_24] Use-prescaler bit selects prescaler clock
// [RULE_25] Reserved codes stop counting, float pin
`timescale 1ns/10ps
`default_nettype none

module timer_prescaler_and_control
    import timer_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  ce_i,
    input  wire logic                  soft_reset_i,
    input  wire logic                  hsel_i,
    input  wire logic [DATA_W-1:0]     haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic [DATA_W-1:0]     hwdata_i,
    input  wire logic                  hready_i,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    output logic [DATA_W-1:0]          hrdata_o,
    input  wire logic                  timer_io_pin_i,
    output logic                       timer_io_pin_o,
    output logic                       timer_io_pin_oe_o,
    output logic [NUM_TIMERS-1:0]      ovf_irq_o,
    output logic [NUM_TIMERS-1:0]      match_irq_o
);

    // --------
    // Decode helpers
    // --------
    function automatic logic [7:0] timer_base(input int idx);
        timer_base = 8'(int'(OFS_TIMER_BASE) + idx * int'(TIMER_STRIDE));
    endfunction

    function automatic logic mode_legal(input int idx, input logic [3:0] m);
        if (idx != 0) begin
            mode_legal = (m == MODE_GPIO);
        end else begin
            mode_legal = (m <= MODE_PWM) || (m == MODE_WD_PULSE) || (m == MODE_WD_TOGGLE);
        end
    endfunction

    function automatic logic mode_compares(input logic [3:0] m);
        mode_compares = (m <= MODE_EVENT) || (m == MODE_PWM)
                     || (m == MODE_WD_PULSE) || (m == MODE_WD_TOGGLE);
    endfunction

    function automatic logic mode_drives(input logic [3:0] m);
        mode_drives = (m == MODE_PULSE) || (m == MODE_TOGGLE) || (m == MODE_PWM)
                   || (m == MODE_WD_PULSE) || (m == MODE_WD_TOGGLE);
    endfunction

    // --------
    // Common clear, bus slave
    // --------
    logic                clr;
    logic                accept;
    logic                wr_pend;
    logic                rd_wait;
    logic [ADDR_W-1:0]   wr_addr;
    logic [ADDR_W-1:0]   rd_addr;
    logic [DATA_W-1:0]   rd_word;
    logic                wr_strobe;

    assign clr       = srst_i | soft_reset_i;
    assign accept    = hsel_i & htrans_i[1] & hready_i;
    assign wr_strobe = wr_pend & ce_i;

    always_ff @(posedge core_clk_i) begin
        if (clr) begin
            wr_pend <= 1'b0;
            rd_wait <= 1'b0;
            wr_addr <= '0;
            rd_addr <= '0;
        end else if (ce_i) begin
            wr_pend <= accept & hwrite_i;
            rd_wait <= accept & ~hwrite_i;
            if (accept) begin
                wr_addr <= haddr_i[ADDR_W-1:0];
                rd_addr <= haddr_i[ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (clr) begin
            hrdata_o <= '0;
        end else if (ce_i && rd_wait) begin
            hrdata_o <= rd_word;
        end
    end

    // Reads take one wait state so a write just before is visible
    assign hreadyout_o = ~rd_wait;
    assign hresp_o     = 1'b0;

    // --------
    // Pin synchroniser and internal half-rate tick
    // --------
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_rise;
    logic pin_fall;
    logic half_phase;
    logic clk2_tick;

    always_ff @(posedge core_clk_i) begin
        if (clr) begin
            pin_s1     <= 1'b0;
            pin_s2     <= 1'b0;
            pin_s3     <= 1'b0;
            half_phase <= 1'b0;
        end else if (ce_i) begin
            pin_s1     <= timer_io_pin_i;  // RULE_06
            pin_s2     <= pin_s1;
            pin_s3     <= pin_s2;
            half_phase <= ~half_phase;
        end
    end

    assign pin_rise  = pin_s2 & ~pin_s3;
    assign pin_fall  = ~pin_s2 & pin_s3;
    assign clk2_tick = half_phase;

    // --------
    // Prescaler
    // --------
    divider_setup_t          setup;
    logic [PRE_W-1:0]        pcnt;
    logic                    pre_en;
    logic                    pre_en_q;
    logic                    pre_tick;
    logic                    pre_pulse;
    logic                    setup_wr;
    logic [NUM_TIMERS-1:0]   uses_pre;

    assign setup_wr = wr_strobe && (wr_addr == OFS_SETUP);
    assign pre_en   = |uses_pre;  // RULE_23
    assign pre_tick = (setup.src == SRC_CLK2) ? clk2_tick  // RULE_04
                    : (setup.src == SRC_PIN)  ? pin_rise   // RULE_05 RULE_06
                    : 1'b0;  // RULE_25

    always_ff @(posedge core_clk_i) begin
        if (clr) begin
            setup.preload <= PRELOAD_RST;  // RULE_03
            setup.src     <= SRC_RST;
        end else if (ce_i && setup_wr) begin
            setup.preload <= hwdata_i[PRE_W-1:0];  // RULE_01
            setup.src     <= hwdata_i[SRC_LSB+1:SRC_LSB];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (clr) begin
            pcnt      <= PRELOAD_RST;
            pre_en_q  <= 1'b0;
            pre_pulse <= 1'b0;
        end else if (ce_i) begin
            pre_en_q  <= pre_en;
            pre_pulse <= 1'b0;
            if (pre_en && !pre_en_q) begin
                pcnt <= setup.preload;  // RULE_01
            end else if (pre_en && pre_tick) begin
                if (pcnt == '0) begin
                    pcnt      <= setup.preload;  // RULE_01 RULE_02
                    pre_pulse <= 1'b1;
                end else begin
                    pcnt <= pcnt - 1'b1;  // RULE_23
                end
            end
        end
    end

    // --------
    // Timers
    // --------
    logic [DATA_W-1:0] t_rdata [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] t_hit;
    logic              pin_drive;
    logic              pin_level;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
            localparam logic [7:0] BASE = timer_base(gi);

            timer_ctrl_t      ctrl;
            logic [CNT_W-1:0] cnt;
            logic [CNT_W-1:0] start_val;
            logic [CNT_W-1:0] match_val;
            logic             first;
            logic             ovf_flag;
            logic             match_flag;
            logic             out_lvl;
            logic             legal;
            logic             src_ev;
            logic             event_ok;
            logic [CNT_W-1:0] next_cnt;
            logic             wrap;
            logic             hit;
            logic             meas_done;
            logic             csr_wr;
            logic             start_wr;
            logic             match_wr;
            logic             sel;
            logic             turn_on;
            logic [DATA_W-1:0] csr_word;

            assign sel      = (rd_addr[7:4] == BASE[7:4]);
            assign csr_wr   = wr_strobe && (wr_addr == (BASE | 8'(OFS_CSR)));
            assign start_wr = wr_strobe && (wr_addr == (BASE | 8'(OFS_START)));
            assign match_wr = wr_strobe && (wr_addr == (BASE | 8'(OFS_MATCH)));
            assign turn_on  = csr_wr && hwdata_i[ON_BIT] && !ctrl.on;

            assign legal  = mode_legal(gi, ctrl.mode);  // RULE_16 RULE_17 RULE_22 RULE_25
            assign src_ev = ctrl.use_prescaler_bit ? pre_pulse  // RULE_24
                          : ((gi == 0) && (ctrl.mode == MODE_EVENT)) ? pin_rise  // RULE_19
                          : clk2_tick;
            assign event_ok = ctrl.on && legal && src_ev;  // RULE_11 RULE_25
            assign next_cnt = first ? start_val : cnt + 1'b1;  // RULE_15
            assign wrap     = event_ok && !first && (cnt == CNT_MAX);  // RULE_13
            assign hit      = event_ok && mode_compares(ctrl.mode)
                           && (next_cnt == match_val);  // RULE_14 RULE_15
            assign meas_done = (gi == 0) && ctrl.on && (
                                  ((ctrl.mode == MODE_WIDTH)   && pin_fall)
                               || ((ctrl.mode == MODE_PERIOD)  && pin_rise)
                               || ((ctrl.mode == MODE_CAPTURE) && pin_rise));
            assign uses_pre[gi] = ctrl.on && ctrl.use_prescaler_bit;  // RULE_23

            always_ff @(posedge core_clk_i) begin
                if (clr) begin
                    ctrl <= CTRL_RST;  // RULE_20
                end else if (ce_i && csr_wr) begin
                    ctrl.on   <= hwdata_i[ON_BIT];  // RULE_11
                    ctrl.oie  <= hwdata_i[OIE_BIT];
                    ctrl.cie  <= hwdata_i[CIE_BIT];
                    ctrl.mode <= hwdata_i[MODE_LSB+3:MODE_LSB];
                    ctrl.dir  <= (gi == 0) ? hwdata_i[DIR_BIT] : 1'b0;
                    ctrl.dout <= (gi == 0) ? hwdata_i[DOUT_BIT] : 1'b0;
                    ctrl.use_prescaler_bit  <= hwdata_i[PCE_BIT];
                end
            end

            always_ff @(posedge core_clk_i) begin
                if (clr) begin
                    start_val <= CNT_RST;
                    match_val <= CNT_RST;
                end else if (ce_i) begin
                    if (start_wr) begin
                        start_val <= hwdata_i[CNT_W-1:0];
                    end
                    if (match_wr) begin
                        match_val <= hwdata_i[CNT_W-1:0];
                    end
                end
            end

            always_ff @(posedge core_clk_i) begin
                if (clr) begin
                    cnt   <= CNT_RST;
                    first <= 1'b0;
                end else if (ce_i) begin
                    if (turn_on) begin
                        cnt   <= CNT_RST;  // RULE_11
                        first <= 1'b1;
                    end else if (event_ok) begin
                        cnt   <= next_cnt;  // RULE_15
                        first <= 1'b0;
                    end
                end
            end

            // Flags: hardware set wins over write-one clear; disabling clears
            always_ff @(posedge core_clk_i) begin
                if (clr) begin
                    ovf_flag   <= 1'b0;
                    match_flag <= 1'b0;
                end else if (ce_i) begin
                    if (wrap) begin
                        ovf_flag <= 1'b1;  // RULE_13
                    end else if ((csr_wr && hwdata_i[OVF_BIT]) || !ctrl.on) begin
                        ovf_flag <= 1'b0;
                    end
                    if (hit || meas_done) begin
                        match_flag <= 1'b1;  // RULE_14
                    end else if ((csr_wr && hwdata_i[MATCH_BIT]) || !ctrl.on) begin
                        match_flag <= 1'b0;
                    end
                end
            end

            // Output level of the driving modes
            always_ff @(posedge core_clk_i) begin
                if (clr) begin
                    out_lvl <= 1'b0;
                end else if (ce_i) begin
                    if (turn_on) begin
                        out_lvl <= 1'b0;
                    end else if ((ctrl.mode == MODE_PULSE) || (ctrl.mode == MODE_WD_PULSE)) begin
                        out_lvl <= hit;
                    end else if ((ctrl.mode == MODE_TOGGLE) || (ctrl.mode == MODE_WD_TOGGLE)) begin
                        out_lvl <= out_lvl ^ hit;
                    end else if (ctrl.mode == MODE_PWM) begin
                        if (hit) begin
                            out_lvl <= 1'b0;
                        end else if (wrap || (event_ok && first)) begin
                            out_lvl <= 1'b1;
                        end
                    end
                end
            end

            assign ovf_irq_o[gi]   = ovf_flag & ctrl.oie;  // RULE_13
            assign match_irq_o[gi] = match_flag & ctrl.cie;  // RULE_14

            assign csr_word = {8'h00, 2'b00, match_flag, ovf_flag, 4'h0, ctrl.use_prescaler_bit,
                               1'b0, ctrl.dout, (gi == 0) ? pin_s2 : 1'b0, ctrl.dir,
                               3'b000, ctrl.mode, 1'b0, ctrl.cie, ctrl.oie, ctrl.on};

            assign t_hit[gi]   = sel;
            assign t_rdata[gi] = (rd_addr[3:0] == OFS_CSR)   ? csr_word
                               : (rd_addr[3:0] == OFS_MATCH) ? {8'h00, match_val}
                               : (rd_addr[3:0] == OFS_COUNT) ? {8'h00, cnt}
                               : '0;

            if (gi == 0) begin : g_pin
                logic gpio_mode;
                logic drive_q;
                logic level_q;

                assign gpio_mode = (ctrl.mode == MODE_GPIO);  // RULE_18

                always_ff @(posedge core_clk_i) begin
                    if (clr) begin
                        drive_q <= 1'b0;
                        level_q <= 1'b0;
                    end else if (ce_i) begin
                        drive_q <= gpio_mode ? ctrl.dir  // RULE_18
                                 : (ctrl.on && legal && mode_drives(ctrl.mode));  // RULE_12 RULE_25
                        level_q <= gpio_mode ? ctrl.dout : out_lvl;
                    end
                end

                assign pin_drive = drive_q;
                assign pin_level = level_q;
            end
        end
    endgenerate

    // --------
    // Read selection and pin
    // --------
    logic [DATA_W-1:0] timer_word;

    assign timer_word = t_hit[0] ? t_rdata[0]
                      : t_hit[1] ? t_rdata[1]
                      : t_hit[2] ? t_rdata[2]
                      : '0;

    assign rd_word = (rd_addr == OFS_SETUP)  ? {9'h000, setup.src, setup.preload}  // RULE_09
                   : (rd_addr == OFS_PCOUNT) ? {11'h000, pcnt}  // RULE_10
                   : timer_word;

    assign timer_io_pin_o    = pin_level;
    assign timer_io_pin_oe_o = pin_drive;

endmodule

`default_nettype wire

// ==== sim/timer_prescaler_and_control_asserts.sv ====
// Port checker for the prescaler and timer block
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler_and_control_asserts
    import timer_pkg::*;
(
    input wire logic                  core_clk_i,
    input wire logic                  srst_i,
    input wire logic                  soft_reset_i,
    input wire logic                  hsel_i,
    input wire logic [DATA_W-1:0]     haddr_i,
    input wire logic [1:0]            htrans_i,
    input wire logic                  hwrite_i,
    input wire logic [DATA_W-1:0]     hwdata_i,
    input wire logic                  hready_i,
    input wire logic                  hreadyout_o,
    input wire logic                  timer_io_pin_o,
    input wire logic                  timer_io_pin_oe_o,
    input wire logic [NUM_TIMERS-1:0] ovf_irq_o,
    input wire logic [NUM_TIMERS-1:0] match_irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // --------
    // Shadow of timer 0 control and cycles since it changed
    // --------
    logic        take;
    logic        clr;
    logic        wr_pend;
    logic [15:0] sh;
    logic [1:0]  age;
    logic [3:0]  md;
    logic        settled;
    assign take    = hsel_i && htrans_i[1] && hready_i;
    assign clr     = srst_i || soft_reset_i;
    assign md      = sh[MODE_LSB+:4];
    assign settled = age == 2'h3;
    always_ff @(posedge core_clk_i) begin
        wr_pend <= take && hwrite_i && haddr_i[7:0] == 8'h10 && !clr;
        sh      <= clr ? 16'h0000 : (wr_pend ? hwdata_i[15:0] : sh);
        age     <= (clr || wr_pend) ? 2'h0 : (settled ? age : age + 2'h1);
    end
    // --------
    // Assertions
    // --------
    a_soft_rst_quiet: assert property (soft_reset_i |=> !timer_io_pin_oe_o
        && ovf_irq_o == 3'h0 && match_irq_o == 3'h0)
        else $error("outputs active after soft reset");
    a_read_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read data phase length wrong");
    a_off_quiet: assert property (settled && !sh[ON_BIT]
        |-> !ovf_irq_o[0] && !match_irq_o[0])
        else $error("interrupt while timer 0 off");
    a_ovf_gate: assert property (settled && !sh[OIE_BIT] |-> !ovf_irq_o[0])
        else $error("overflow interrupt while masked");
    a_match_gate: assert property (settled && !sh[CIE_BIT] |-> !match_irq_o[0])
        else $error("match interrupt while masked");
    a_pin_float: assert property (settled && !sh[ON_BIT] && md != MODE_GPIO
        |-> !timer_io_pin_oe_o)
        else $error("pin driven while timer off");
    a_rsvd_float: assert property (settled && (md == 4'h8 || md > MODE_WD_TOGGLE)
        |-> !timer_io_pin_oe_o)
        else $error("pin driven in reserved mode");
    a_gpio_drive: assert property (settled && md == MODE_GPIO && sh[DIR_BIT]
        |-> timer_io_pin_oe_o && timer_io_pin_o == sh[DOUT_BIT])
        else $error("gpio output not driven");
    c_read: cover property (take && !hwrite_i);
    c_ovf: cover property ($rose(ovf_irq_o[0]));
    c_gpio: cover property (timer_io_pin_oe_o && timer_io_pin_o);
endmodule
bind timer_prescaler_and_control timer_prescaler_and_control_asserts
    i_timer_prescaler_and_control_asserts (.core_clk_i, .srst_i, .soft_reset_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .timer_io_pin_o,
    .timer_io_pin_oe_o, .ovf_irq_o, .match_irq_o);
`default_nettype wire

// ==== sim/timer_pin_src.sv ====
// External signal source on the timer pin
`timescale 1ns/10ps
`default_nettype none
module timer_pin_src #(
    parameter int HALF = 4
) (
    input  wire logic clk_i,
    input  wire logic en_i,
    input  wire logic dut_oe_i,
    input  wire logic dut_lvl_i,
    output logic      pin_o
);
    int   cnt;
    logic sq;
    always @(posedge clk_i) begin
        cnt <= (!en_i || cnt == HALF - 1) ? 0 : cnt + 1;
        sq  <= !en_i ? 1'b0 : (cnt == HALF - 1 ? ~sq : sq);
    end
    // Released line carries the square wave while enabled, else falls to the pull-down
    assign pin_o = dut_oe_i ? dut_lvl_i : (en_i & sq);
endmodule
`default_nettype wire

// ==== sim/timer_prescaler_and_control_tb_top.sv ====
// Self-checking bench for the prescaler and timer block
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler_and_control_tb_top
    import timer_pkg::*;
;
    logic                  core_clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, soft_reset_i = 1'b0;
    logic                  hsel_i = 1'b1, hwrite_i = 1'b0, hready_i, pin_en = 1'b0;
    logic [DATA_W-1:0]     haddr_i = '0, hwdata_i = '0, hrdata_o;
    logic [1:0]            htrans_i = 2'h0;
    logic [2:0]            hsize_i = 3'h2;
    logic                  hreadyout_o, hresp_o, timer_io_pin_i, timer_io_pin_o, timer_io_pin_oe_o;
    logic [NUM_TIMERS-1:0] ovf_irq_o, match_irq_o;
    int                    errors = 0, cmp_count = 0;
    assign hready_i = hreadyout_o;
    always #50 core_clk_i = ~core_clk_i;
    timer_prescaler_and_control i_timer_prescaler_and_control (.core_clk_i, .srst_i, .ce_i,
        .soft_reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i,
        .hreadyout_o, .hresp_o, .hrdata_o, .timer_io_pin_i, .timer_io_pin_o, .timer_io_pin_oe_o,
        .ovf_irq_o, .match_irq_o);
    timer_pin_src i_timer_pin_src (.clk_i(core_clk_i), .en_i(pin_en),
        .dut_oe_i(timer_io_pin_oe_o), .dut_lvl_i(timer_io_pin_o), .pin_o(timer_io_pin_i));
    // --------
    // Shared tasks
    // --------
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic phase(output logic r, output logic [31:0] q);
        do begin
            @(negedge core_clk_i);
            q = hrdata_o;
            r = hreadyout_o;
            @(posedge core_clk_i);
        end while (r !== 1'b1);
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        logic r;
        htrans_i <= 2'h2;
        haddr_i  <= {24'h000000, a};
        hwrite_i <= w;
        phase(r, q);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        phase(r, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(a, 1'b0, 32'h00000000, q);
    endtask
    task automatic sreset();
        soft_reset_i <= 1'b1;
        @(posedge core_clk_i);
        soft_reset_i <= 1'b0;
        pin_en       <= 1'b0;
    endtask
    // --------
    // Scenarios
    // --------
    task automatic t_regs();
        logic [31:0] q, q2;
        sreset();
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, q);
        rd(8'h08, q2);
        chk(q === 32'h0 && q2 === 32'h0 && hresp_o === 1'b0, "read-only or unmapped");
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, q);
        chk(q === 32'h007FFFFF, "setup bit 23");
        wr(8'h10, 32'h000000F6);
        sreset();
        rd(8'h00, q);
        rd(8'h10, q2);
        chk(q === 32'h0 && q2 === 32'h0, "soft reset fields");
        wr(8'h00, 32'h000000FF);
        wr(8'h10, 32'h00008001);
        rd(8'h04, q);
        ce_i <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        ce_i <= 1'b1;
        rd(8'h04, q2);
        chk(q <= 32'hFF && (q - q2 === 32'h1 || q - q2 === 32'h2), "live count");
    endtask
    task automatic t_ovf();
        logic [31:0] q;
        sreset();
        wr(8'h14, 32'h00FFFFFE);
        wr(8'h10, 32'h00000003);
        for (int k = 0; k < 20 && ovf_irq_o[0] !== 1'b1; k++) @(posedge core_clk_i);
        rd(8'h10, q);
        chk(ovf_irq_o[0] === 1'b1 && q[OVF_BIT] === 1'b1, "no overflow");
        wr(8'h10, 32'h00000002);
        repeat (3) @(posedge core_clk_i);
        chk(ovf_irq_o[0] === 1'b0, "flag kept after disable");
    endtask
    task automatic t_pins();
        sreset();
        for (int m = 0; m < 16; m++) begin
            wr(8'h10, 32'h00002800 | (m << 4));
            repeat (3) @(posedge core_clk_i);
            chk(timer_io_pin_oe_o === !m && (m || timer_io_pin_o), "pin off");
            wr(8'h10, 32'h00002801 | (m << 4));
            repeat (3) @(posedge core_clk_i);
            chk(timer_io_pin_oe_o === (m inside {0,1,2,7,9,10}), "oe");
            wr(8'h10, 32'h00002800 | (m << 4));
        end
    endtask
    task automatic t_t12();
        sreset();
        wr(8'h28, 32'h00000001);
        wr(8'h38, 32'h00000001);
        wr(8'h20, 32'h00000015);
        wr(8'h30, 32'h00000005);
        repeat (40) @(posedge core_clk_i);
        chk(match_irq_o === 3'b100, "timers 1 and 2 modes");
    endtask
    task automatic meas(input logic [31:0] su, input logic [31:0] ct, input logic [23:0] n,
                        output int c);
        sreset();
        wr(8'h00, su);
        wr(8'h14, 32'h00000000);
        wr(8'h18, {8'h00, n});
        pin_en <= 1'b1;
        wr(8'h10, ct);
        for (c = 0; c < 400; c++) begin
            @(negedge core_clk_i);
            if (match_irq_o[0] === 1'b1) break;
            @(posedge core_clk_i);
        end
        @(posedge core_clk_i);
    endtask
    task automatic t_div(input logic [31:0] su, input logic [31:0] ct, input int gap);
        int c1, c3;
        meas(su, ct, 24'h000001, c1);
        meas(su, ct, 24'h000003, c3);
        chk(gap ? (c1 < 400 && c3 - c1 == gap) : (c1 + c3 == 800), "match spacing");
    endtask
    initial begin
        repeat (20) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        t_regs();
        t_ovf();
        t_pins();
        t_t12();
        t_div(32'h00000003, 32'h00008005, 16);
        t_div(32'h00000000, 32'h00008005, 4);
        t_div(32'h00200001, 32'h00008005, 32);
        t_div(32'h00000000, 32'h00000035, 16);
        t_div(32'h00400000, 32'h00008005, 0);
        tally_and_finish();
    end
    initial begin
        #(20000 * 100);
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
